//--- hdl/ltfc_debounce.sv
`timescale 1ns/1ps
module ltfc_debounce
  import ltfc_pkg::*;
#(
  parameter int STABLE_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // raw pin, idle high
  input wire logic i_raw,
  // qualified level and press event
  output logic o_level,
  output logic o_fall
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic fall;
    logic [21:0] cnt;
  } ltfc_db_t;

  localparam ltfc_db_t DB_RESET = '{sync1: 1'b1, sync2: 1'b1, level: 1'b1,
                                    fall: 1'b0, cnt: 22'h00_0000};

  ltfc_db_t r;
  ltfc_db_t next_r;

  always_comb begin
    next_r = r;
    next_r.sync1 = i_raw;
    next_r.sync2 = r.sync1;
    next_r.fall = 1'b0;
    // both edges need the same stable time before acceptance
    if (r.sync2 == r.level) begin
      next_r.cnt = '0;
    end else if (r.cnt >= 22'(STABLE_CYC - 1)) begin
      next_r.cnt = '0;
      next_r.level = r.sync2;
      next_r.fall = ~r.sync2;
    end else begin
      next_r.cnt = r.cnt + 22'h00_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      r <= DB_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign o_level = r.level;
  assign o_fall = r.fall;

endmodule

//--- hdl/ltfc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - after reset the latch is off, output zero unless active PWM drives it, until a qualified press.
// - press while off latches on and ramps from zero to the setpoint.
// - press while latched on ramps down to zero over the fade-out time.
// - toggle input is filtered so one press is one event, about 37 ms.
// - the same qualification applies to falling and rising toggle edges.
// - button fades step through 63 gamma levels, up or down.
// - gamma levels follow the fixed 63-entry permille table, 0 to 1000.
// - a press during a ramp flips the target and redirects the ramp.
// - fade-in and fade-out times are set separately, 2.5 us per ohm.
// - grounded timing pin makes that fade about 70 us; debounce stays.
// - active PWM bypasses gamma and ramps; output follows PWM directly.
// - once the button latch turned the channel on, PWM is ignored.
// - button wins over PWM; a press toggles even with PWM present.
// - PWM duty 0 to 100 percent scales the setpoint linearly.
// - below 4.5 V supply the source turns off, latch kept above 3.8 V.
// - below 3.8 V the latch returns to its off default.
// - above 4.6 V the source returns, following the kept latch.
// - short lasting the persistence time cuts output to 20 percent.
// - setpoint pin short to ground clamps current near 205 mA.
// - positive variant passes PWM as is; negative variant is active low.
// - short persistence time is nominally 5 ms.
// - debounce time lies between 25 ms and 50 ms.
module ltfc_top
  import ltfc_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int FAULT_CYCLES = FAULT_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // push button, low while pressed
  input wire logic i_toggle_n,
  // external pwm and polarity strap (high selects active low pwm)
  input wire logic i_pwm,
  input wire logic i_pwm_active_low,
  // fade time programming, resistor in kilo-ohm, and grounded flags
  input wire logic [9:0] i_fade_in_resistor,
  input wire logic [9:0] i_fade_out_resistor,
  input wire logic i_fade_in_time_pin_gnd,
  input wire logic i_fade_out_time_pin_gnd,
  // analog comparators
  input wire logic i_supply_below_4v5,
  input wire logic i_supply_above_4v6,
  input wire logic i_supply_below_3v8,
  input wire logic i_out_below_short_detect_threshold,
  input wire logic i_current_program_pin_short,
  // current regulator control
  output logic [9:0] o_level_permille,
  output logic o_source_enable,
  output logic o_current_clamp,
  // status
  output logic o_latch_on,
  output logic o_pwm_mode,
  output logic o_low_supply_lockout,
  output logic o_short_fault,
  output logic o_fading
);

  localparam int NSYNC = 9;

  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [9:0] in_kohm1;
    logic [9:0] in_kohm2;
    logic [9:0] out_kohm1;
    logic [9:0] out_kohm2;
    logic latch_on;
    logic lockout;
    ltfc_fade_t fade;
    logic [5:0] idx;
    logic [26:0] step_cnt;
    logic [17:0] fault_cnt;
    logic short_fault;
    logic pwm_mode;
    logic [9:0] level;
    logic source_en;
    logic clamp;
  } ltfc_state_t;

  localparam ltfc_state_t ST_RESET = '{
    sync1: '0, sync2: '0, in_kohm1: '0, in_kohm2: '0,
    out_kohm1: '0, out_kohm2: '0, latch_on: 1'b0, lockout: 1'b0,
    fade: LTFC_FADE_IDLE, idx: GAMMA_FIRST, step_cnt: '0, fault_cnt: '0,
    short_fault: 1'b0, pwm_mode: 1'b0, level: LEVEL_ZERO,
    source_en: 1'b0, clamp: 1'b0
  };

  ltfc_state_t r;
  ltfc_state_t next_r;

  logic tog_level;
  logic tog_fall;

  // button filter keeps its own synchroniser
  ltfc_debounce #(
    .STABLE_CYC(DEBOUNCE_CYCLES)
  ) u_debounce (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_raw(i_toggle_n),
    .o_level(tog_level),
    .o_fall(tog_fall)
  );

  // synchronised single-bit pins
  logic pwm_s;
  logic pol_low_s;
  logic in_gnd_s;
  logic out_gnd_s;
  logic uv_enter_s;
  logic uv_release_s;
  logic latch_lost_s;
  logic short_s;
  logic current_program_pin_short_s;

  assign pwm_s = r.sync2[0];
  assign pol_low_s = r.sync2[1];
  assign in_gnd_s = r.sync2[2];
  assign out_gnd_s = r.sync2[3];
  assign uv_enter_s = r.sync2[4];
  assign uv_release_s = r.sync2[5];
  assign latch_lost_s = r.sync2[6];
  assign short_s = r.sync2[7];
  assign current_program_pin_short_s = r.sync2[8];

  // step length per direction: an equal share of the total fade time
  logic [26:0] up_step_len;
  logic [26:0] dn_step_len;

  always_comb begin
    logic [26:0] up_total;
    logic [26:0] dn_total;
    logic [26:0] up_q;
    logic [26:0] dn_q;
    up_total = 27'(r.in_kohm2) * FADE_CYC_PER_KOHM;
    dn_total = 27'(r.out_kohm2) * FADE_CYC_PER_KOHM;
    up_q = up_total / GAMMA_STEPS_W;
    dn_q = dn_total / GAMMA_STEPS_W;
    // a step never shrinks below one cycle
    if (up_q == '0) begin
      up_q = 27'h000_0001;
    end
    if (dn_q == '0) begin
      dn_q = 27'h000_0001;
    end
    up_step_len = in_gnd_s ? INSTANT_STEP_CYC : up_q;
    dn_step_len = out_gnd_s ? INSTANT_STEP_CYC : dn_q;
  end

  // pwm after polarity correction
  logic pwm_active;
  assign pwm_active = pwm_s ^ pol_low_s;

  logic [26:0] cur_step_len;
  logic [9:0] base_level;

  always_comb begin
    next_r = r;

    next_r.sync1 = {i_current_program_pin_short, i_out_below_short_detect_threshold,
                    i_supply_below_3v8, i_supply_above_4v6, i_supply_below_4v5,
                    i_fade_out_time_pin_gnd, i_fade_in_time_pin_gnd,
                    i_pwm_active_low, i_pwm};
    next_r.sync2 = r.sync1;
    // resistor codes are quasi static straps, a two-stage register suffices
    next_r.in_kohm1 = i_fade_in_resistor;
    next_r.in_kohm2 = r.in_kohm1;
    next_r.out_kohm1 = i_fade_out_resistor;
    next_r.out_kohm2 = r.out_kohm1;

    // supply lockout with hysteresis between entry and release
    if (uv_enter_s) begin
      next_r.lockout = 1'b1;
    end else if (uv_release_s) begin
      next_r.lockout = 1'b0;
    end

    // toggle latch; press is honoured regardless of pwm activity
    if (tog_fall) begin
      next_r.latch_on = ~r.latch_on;
    end
    if (latch_lost_s) begin
      next_r.latch_on = 1'b0;
    end

    cur_step_len = (r.fade == LTFC_FADE_DOWN) ? dn_step_len : up_step_len;

    // fade engine; direction follows the latch, index is reset only when the latch is lost
    case (r.fade)
      LTFC_FADE_IDLE: begin
        next_r.step_cnt = '0;
        if (next_r.latch_on && r.idx != GAMMA_LAST) begin
          next_r.fade = LTFC_FADE_UP;
        end else if (!next_r.latch_on && r.idx != GAMMA_FIRST) begin
          next_r.fade = LTFC_FADE_DOWN;
        end
      end
      LTFC_FADE_UP: begin
        if (!next_r.latch_on) begin
          next_r.fade = LTFC_FADE_DOWN;
          next_r.step_cnt = '0;
        end else if (r.step_cnt >= cur_step_len - 27'h000_0001) begin
          next_r.step_cnt = '0;
          next_r.idx = r.idx + 6'h01;
          if (r.idx + 6'h01 == GAMMA_LAST) begin
            next_r.fade = LTFC_FADE_IDLE;
          end
        end else begin
          next_r.step_cnt = r.step_cnt + 27'h000_0001;
        end
      end
      LTFC_FADE_DOWN: begin
        if (next_r.latch_on) begin
          next_r.fade = LTFC_FADE_UP;
          next_r.step_cnt = '0;
        end else if (r.step_cnt >= cur_step_len - 27'h000_0001) begin
          next_r.step_cnt = '0;
          next_r.idx = r.idx - 6'h01;
          if (r.idx - 6'h01 == GAMMA_FIRST) begin
            next_r.fade = LTFC_FADE_IDLE;
          end
        end else begin
          next_r.step_cnt = r.step_cnt + 27'h000_0001;
        end
      end
      default: begin
        next_r.fade = LTFC_FADE_IDLE;
        next_r.step_cnt = '0;
      end
    endcase

    // a lost latch also drops the ramp position so power-up starts dark
    if (latch_lost_s) begin
      next_r.idx = GAMMA_FIRST;
      next_r.fade = LTFC_FADE_IDLE;
      next_r.step_cnt = '0;
    end

    // pwm may drive only when the latch is off and the fade-out is over
    next_r.pwm_mode = !next_r.latch_on && next_r.fade == LTFC_FADE_IDLE
                      && next_r.idx == GAMMA_FIRST;

    // output short must persist before the current is cut back
    if (!short_s) begin
      next_r.fault_cnt = '0;
      next_r.short_fault = 1'b0;
    end else if (r.fault_cnt >= 18'(FAULT_CYCLES - 1)) begin
      next_r.short_fault = 1'b1;
    end else begin
      next_r.fault_cnt = r.fault_cnt + 18'h0_0001;
    end

    // level composition
    if (r.pwm_mode) begin
      base_level = pwm_active ? LEVEL_FULL : LEVEL_ZERO;
    end else begin
      base_level = GAMMA_LUT[r.idx];
    end
    if (r.short_fault) begin
      base_level = base_level / SHORT_DIVISOR;
    end
    if (r.lockout) begin
      base_level = LEVEL_ZERO;
    end
    next_r.level = base_level;
    next_r.source_en = !r.lockout && base_level != LEVEL_ZERO;
    // the regulator applies the 205 mA ceiling while this is high
    next_r.clamp = current_program_pin_short_s;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      r <= ST_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign o_level_permille = r.level;
  assign o_source_enable = r.source_en;
  assign o_current_clamp = r.clamp;
  assign o_latch_on = r.latch_on;
  assign o_pwm_mode = r.pwm_mode;
  assign o_low_supply_lockout = r.lockout;
  assign o_short_fault = r.short_fault;
  assign o_fading = r.fade != LTFC_FADE_IDLE;

endmodule

//--- include/ltfc_pkg.sv
package ltfc_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 25;

  // gamma ramp geometry
  localparam int GAMMA_STEPS = 63;
  localparam logic [5:0] GAMMA_LAST = 6'h3E;
  localparam logic [5:0] GAMMA_FIRST = 6'h00;
  localparam logic [9:0] LEVEL_FULL = 10'h3E8;
  localparam logic [9:0] LEVEL_ZERO = 10'h000;

  // levels in parts per thousand of the setpoint
  localparam logic [9:0] GAMMA_LUT [0:62] = '{
    10'd0, 10'd2, 10'd4, 10'd6, 10'd8, 10'd10, 10'd12, 10'd16,
    10'd20, 10'd24, 10'd28, 10'd32, 10'd36, 10'd42, 10'd48, 10'd54,
    10'd60, 10'd66, 10'd72, 10'd80, 10'd88, 10'd96, 10'd104, 10'd112,
    10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
    10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
    10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
    10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
    10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000
  };

  // fade time: 2.5 us per ohm, resistor given in kilo-ohm
  localparam int FADE_NS_PER_KOHM = 2500000;
  localparam logic [26:0] FADE_CYC_PER_KOHM = 27'(FADE_NS_PER_KOHM / CLK_PERIOD_NS);
  localparam logic [26:0] GAMMA_STEPS_W = 27'(GAMMA_STEPS);

  // grounded timing pin: whole ramp in about 70 us
  localparam int INSTANT_TIME_NS = 70000;
  localparam logic [26:0] INSTANT_STEP_CYC =
    27'(INSTANT_TIME_NS / CLK_PERIOD_NS / GAMMA_STEPS);

  // debounce, nominal 37 ms (allowed 25..50 ms)
  localparam int DEBOUNCE_TIME_US = 37000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_TIME_US * 1000 / CLK_PERIOD_NS;

  // output short persistence, 5 ms
  localparam int FAULT_TIME_US = 5000;
  localparam int FAULT_CYC = FAULT_TIME_US * 1000 / CLK_PERIOD_NS;

  // short fault reduces output to 20 percent, i.e. level / 5
  localparam logic [9:0] SHORT_DIVISOR = 10'h005;

  typedef enum logic [2:0] {
    LTFC_FADE_IDLE = 3'b001,
    LTFC_FADE_UP = 3'b010,
    LTFC_FADE_DOWN = 3'b100
  } ltfc_fade_t;

endpackage

//--- sim/ltfc_peer.sv
`timescale 1ns/1ps
module ltfc_peer (
  // clock
  input wire logic i_clk,
  // button and pwm pins
  output logic o_toggle_n,
  output logic o_pwm
);
  initial begin
    o_toggle_n = 1'b1;
    o_pwm = 1'b0;
  end
  // released button sits at the pull-up level
  task automatic press(input int low_cyc, input int high_cyc);
    @(posedge i_clk);
    #2 o_toggle_n = 1'b0;
    repeat (low_cyc) @(posedge i_clk);
    #2 o_toggle_n = 1'b1;
    repeat (high_cyc) @(posedge i_clk);
  endtask
  // slow level steps, far below the upper recommended rate
  task automatic set_pwm(input logic lvl);
    @(posedge i_clk);
    #2 o_pwm = lvl;
  endtask
endmodule

//--- sim/ltfc_props.sv
`timescale 1ns/1ps
module ltfc_props (
  // clock, reset and pins
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_toggle_n,
  input wire logic i_pwm,
  input wire logic i_pwm_active_low,
  input wire logic i_supply_below_4v5,
  input wire logic i_supply_below_3v8,
  input wire logic i_out_below_short_detect_threshold,
  input wire logic i_current_program_pin_short,
  // design outputs
  input wire logic [9:0] o_level_permille,
  input wire logic o_source_enable,
  input wire logic o_current_clamp,
  input wire logic o_latch_on,
  input wire logic o_pwm_mode,
  input wire logic o_low_supply_lockout,
  input wire logic o_short_fault
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_level_max;
    o_level_permille <= 10'h03E8;
  endproperty
  property p_press_cause;
    $rose(o_latch_on) |-> !$past(i_toggle_n, 3);
  endproperty
  property p_on_ignores_pwm;
    o_latch_on && $past(o_latch_on) |-> !o_pwm_mode;
  endproperty
  property p_lockout_entry;
    i_supply_below_4v5 [*6] |-> o_low_supply_lockout;
  endproperty
  property p_lockout_dark;
    o_low_supply_lockout && $past(o_low_supply_lockout) |->
      !o_source_enable && o_level_permille == 10'h0000;
  endproperty
  property p_latch_lost;
    i_supply_below_3v8 [*6] |-> !o_latch_on;
  endproperty
  property p_clamp;
    o_current_clamp == $past(i_current_program_pin_short, 3);
  endproperty
  // clear and set share one latency of depth 3; depth 4 is allowed as well
  property p_fault_cause;
    o_short_fault |-> $past(i_out_below_short_detect_threshold, 3) ||
      $past(i_out_below_short_detect_threshold, 4);
  endproperty
  property p_fault_level;
    o_short_fault && $past(o_short_fault) |-> o_level_permille <= 10'h00C8;
  endproperty
  property p_pwm_follow;
    (o_pwm_mode && !o_short_fault && !o_low_supply_lockout &&
      $stable(i_pwm ^ i_pwm_active_low)) [*6] |->
      o_level_permille == ((i_pwm ^ i_pwm_active_low) ? 10'h03E8 : 10'h0000);
  endproperty
  a_level_max: assert property (p_level_max) else $error("level above full");
  a_press_cause: assert property (p_press_cause) else $error("latch set without press");
  a_on_ignores_pwm: assert property (p_on_ignores_pwm) else $error("pwm while on");
  a_lockout_entry: assert property (p_lockout_entry) else $error("no lockout");
  a_lockout_dark: assert property (p_lockout_dark) else $error("lit in lockout");
  a_latch_lost: assert property (p_latch_lost) else $error("latch kept");
  a_clamp: assert property (p_clamp) else $error("clamp wrong");
  a_fault_cause: assert property (p_fault_cause) else $error("fault w/o short");
  a_fault_level: assert property (p_fault_level) else $error("fault level high");
  a_pwm_follow: assert property (p_pwm_follow) else $error("pwm not followed");
  c_on: cover property ($rose(o_latch_on));
  c_off: cover property ($fell(o_latch_on));
  c_fault: cover property ($rose(o_short_fault));
endmodule
bind ltfc_top ltfc_props u_props (.i_clk, .i_rstn, .i_toggle_n, .i_pwm, .i_pwm_active_low,
  .i_supply_below_4v5, .i_supply_below_3v8, .i_out_below_short_detect_threshold,
  .i_current_program_pin_short, .o_level_permille, .o_source_enable, .o_current_clamp,
  .o_latch_on, .o_pwm_mode, .o_low_supply_lockout, .o_short_fault);

//--- sim/ltfc_top_tb.sv
`timescale 1ns/1ps
module ltfc_top_tb;
  import ltfc_pkg::*;
  localparam int DB = 20;
  localparam int FC = 16;
  logic i_clk, i_rstn, i_toggle_n, i_pwm, i_pwm_active_low;
  logic i_fade_in_time_pin_gnd, i_fade_out_time_pin_gnd;
  logic i_supply_below_4v5, i_supply_above_4v6, i_supply_below_3v8;
  logic i_out_below_short_detect_threshold, i_current_program_pin_short;
  logic [9:0] i_fade_in_resistor, i_fade_out_resistor, o_level_permille, prev, cap;
  logic o_source_enable, o_current_clamp, o_latch_on, o_pwm_mode;
  logic o_low_supply_lockout, o_short_fault, o_fading;
  int err_count, n_checks, cyc, steps;
  ltfc_top #(.DEBOUNCE_CYCLES(DB), .FAULT_CYCLES(FC)) u_dut (.i_clk, .i_rstn, .i_toggle_n,
    .i_pwm, .i_pwm_active_low, .i_fade_in_resistor, .i_fade_out_resistor,
    .i_fade_in_time_pin_gnd, .i_fade_out_time_pin_gnd, .i_supply_below_4v5,
    .i_supply_above_4v6, .i_supply_below_3v8, .i_out_below_short_detect_threshold,
    .i_current_program_pin_short, .o_level_permille, .o_source_enable, .o_current_clamp,
    .o_latch_on, .o_pwm_mode, .o_low_supply_lockout, .o_short_fault, .o_fading);
  ltfc_peer u_peer (.i_clk, .o_toggle_n(i_toggle_n), .o_pwm(i_pwm));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // level changes seen, so a ramp can be counted step by step
  always @(posedge i_clk) begin
    if (o_level_permille !== prev) steps++;
    prev <= o_level_permille;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    {i_rstn, i_pwm_active_low, i_fade_in_time_pin_gnd, i_fade_out_time_pin_gnd} = 4'h0;
    {i_supply_below_4v5, i_supply_above_4v6, i_supply_below_3v8} = 3'b010;
    {i_out_below_short_detect_threshold, i_current_program_pin_short} = 2'b00;
    i_fade_in_resistor = 10'h000;
    i_fade_out_resistor = 10'h000;
    {err_count, n_checks, cyc, steps} = '0;
    tick(4);
    i_rstn = 1'b1;
    tick(3);
    check("latch", 10'h0000, o_latch_on);
    u_peer.set_pwm(1'b1);
    tick(8);
    check("pwm level", 10'h03E8, o_level_permille);
    i_pwm_active_low = 1'b1;
    tick(8);
    check("inverted pwm", 10'h0000, o_level_permille);
    i_pwm_active_low = 1'b0;
    u_peer.press(DB - 6, DB + 4);
    check("glitch", 10'h0000, o_latch_on);
    u_peer.set_pwm(1'b0);
    tick(8);
    steps = 0;
    u_peer.press(DB + 4, DB + 4);
    tick(80);
    check("up steps", 10'd62, 10'(steps));
    check("up end", 10'h03E8, o_level_permille);
    u_peer.set_pwm(1'b1);
    tick(8);
    u_peer.set_pwm(1'b0);
    tick(8);
    check("pwm ignored", 10'h03E8, o_level_permille);
    i_out_below_short_detect_threshold = 1'b1;
    tick(FC + 8);
    check("fault", 10'h0001, o_short_fault);
    check("fault level", 10'h00C8, o_level_permille);
    i_out_below_short_detect_threshold = 1'b0;
    tick(6);
    check("restored", 10'h03E8, o_level_permille);
    i_current_program_pin_short = 1'b1;
    tick(4);
    check("clamp", 10'h0001, o_current_clamp);
    i_current_program_pin_short = 1'b0;
    {i_supply_below_4v5, i_supply_above_4v6} = 2'b10;
    tick(8);
    check("locked src", 10'h0000, o_source_enable);
    check("latch kept", 10'h0001, o_latch_on);
    {i_supply_below_4v5, i_supply_above_4v6} = 2'b01;
    tick(8);
    check("src back", 10'h0001, o_source_enable);
    i_fade_out_time_pin_gnd = 1'b1;
    steps = 0;
    u_peer.press(DB + 4, DB + 4);
    tick(2800);
    check("down steps", 10'd62, 10'(steps));
    check("down end", 10'h0000, o_level_permille);
    u_peer.set_pwm(1'b1);
    tick(8);
    i_fade_in_time_pin_gnd = 1'b1;
    // a long resistor must not slow the fade while its pin is grounded
    i_fade_in_resistor = 10'h001;
    u_peer.press(DB + 4, DB + 4);
    check("press over pwm", 10'h0001, o_latch_on);
    u_peer.set_pwm(1'b0);
    tick(400);
    u_peer.press(DB + 4, DB + 4);
    check("redirect", 10'h0000, o_latch_on);
    cap = o_level_permille;
    tick(100);
    check("reversed", 10'h0001, 10'(o_level_permille < cap));
    tick(700);
    check("back at zero", 10'h0000, o_level_permille);
    i_fade_in_time_pin_gnd = 1'b0;
    u_peer.press(DB + 4, DB + 4);
    tick(80);
    i_supply_below_3v8 = 1'b1;
    tick(8);
    check("latch lost", 10'h0000, o_latch_on);
    check("dark", 10'h0000, o_level_permille);
    print_verdict();
  end
endmodule
